// ===== verilog/exec_pkg.sv
/*
 * Shared constants and types for the instruction-subset execution unit.
 * Assumes a decode stage that presents one decoded instruction per issue
 * pulse and a register file outside that applies the returned writes.
 */
// What this block does
// - Signed 16-bit add with small signed shift into accumulator; only acc flags change.
// - Add-with-carry sums operands plus carry; one cycle; sets C, DC, N, OV, Z.
// - One-bit arithmetic right shift keeps sign; sets C, N, OV, Z.
// - Multi-bit arithmetic right shift by register or 5-bit literal; sets N, Z only.
// - Conditional branch: one cycle not taken, two taken, no flag change.
// - Branches test accumulator A and accumulator B overflow flags.
// - Branches test accumulator A and accumulator B saturation flags.
// - Signed and unsigned compare branches derived from arithmetic flags.
// - Branches on overflow, carry, negative and zero both set and clear.
// - Multiply operands only the six distinct pairs from registers four to seven.
// - Square uses one operand twice, limited to registers four to seven.
// - File-register forms use working register zero as implicit operand.
// - X prefetch uses register 8 or 9: none, +-2/4/6, index by 12, or off.
// - Y prefetch uses register 10 or 11 with the same options as X.
// - Prefetched operands are written only into registers four to seven.
package exec_pkg;

	localparam int DATA_W = 16;
	localparam int ACC_W  = 40;
	localparam int SHAMT_W = 5;
	localparam int DEFAULT_WORK_REG_W = 4;

	// Register numbers with fixed roles
	localparam logic [3:0] DEFAULT_WORK_REG = 4'h0;
	localparam logic [3:0] MUL_REG_LO       = 4'h4;
	localparam logic [3:0] MUL_REG_HI       = 4'h7;
	localparam logic [3:0] X_PTR_A          = 4'h8;
	localparam logic [3:0] X_PTR_B          = 4'h9;
	localparam logic [3:0] Y_PTR_A          = 4'ha;
	localparam logic [3:0] Y_PTR_B          = 4'hb;
	localparam logic [3:0] INDEX_REG        = 4'hc;

	// Cycle counts
	localparam logic [1:0] CYC_ONE = 2'h1;
	localparam logic [1:0] CYC_TWO = 2'h2;

	// Nibble boundary for the add-with-carry digit carry flag
	localparam int NIB_W = 4;

	typedef enum logic [3:0] {
		OP_NOP, OP_ADD_ACC, OP_ADD_WITH_CARRY_OP, OP_AND, OP_ASR1, OP_ASRN,
		OP_BRANCH_COND, OP_BRANCH_ALWAYS, OP_MUL, OP_SQR
	} op_t;

	// Branch conditions
	typedef enum logic [4:0] {
		CC_C, CC_GE, CC_GEU, CC_GT, CC_GTU, CC_LE, CC_LEU, CC_LT, CC_LTU,
		CC_N, CC_NC, CC_NN, CC_NOV, CC_NZ, CC_OA, CC_OB, CC_OV, CC_SA,
		CC_SB, CC_Z
	} cond_t;

	// Prefetch modification field
	typedef enum logic [2:0] {
		PF_NONE, PF_PLAIN, PF_INC2, PF_INC4, PF_INC6,
		PF_DEC2, PF_DEC4, PF_DEC6
	} pf_mod_t;

endpackage : exec_pkg

// ===== verilog/prefetch_agu.sv
/*
 * Address unit for one operand prefetch space.
 * Assumes the caller supplies the current pointer and index register values.
 */
`timescale 1ns/10ps
module prefetch_agu #(
	parameter logic [3:0] PTR_A = 4'h8,
	parameter logic [3:0] PTR_B = 4'h9
) (
	// Request
	input  wire logic              en_i,
	input  wire logic              sel_b_i,
	input  wire logic              indexed_i,
	input  wire exec_pkg::pf_mod_t mod_i,
	input  wire logic [3:0]        dst_i,
	input  wire logic [15:0]       ptr_val_i,
	input  wire logic [15:0]       idx_val_i,
	// Result
	output logic                   rd_o,
	output logic [15:0]            addr_o,
	output logic                   ptr_we_o,
	output logic [3:0]             ptr_reg_o,
	output logic [15:0]            ptr_new_o,
	output logic                   dst_ok_o
);
	import exec_pkg::*;

	logic [15:0] step;

	// Pointer update step from the modification field
	always_comb begin
		step = 16'h0000;
		case (mod_i)
			PF_INC2: step = 16'h0002;
			PF_INC4: step = 16'h0004;
			PF_INC6: step = 16'h0006;
			PF_DEC2: step = 16'hfffe;
			PF_DEC4: step = 16'hfffc;
			PF_DEC6: step = 16'hfffa;
			default: step = 16'h0000;
		endcase
	end

	// Address, pointer write-back and destination check
	always_comb begin
		rd_o      = en_i && (mod_i != PF_NONE || indexed_i);
		ptr_reg_o = (sel_b_i || indexed_i) ? PTR_B : PTR_A;
		addr_o    = indexed_i ? ptr_val_i + idx_val_i : ptr_val_i;
		ptr_we_o  = rd_o && !indexed_i && (step != 16'h0000);
		ptr_new_o = ptr_val_i + step;
		dst_ok_o  = (dst_i >= MUL_REG_LO) && (dst_i <= MUL_REG_HI);
	end

endmodule : prefetch_agu

// ===== verilog/exec_unit.sv
/*
 * Execution unit for an instruction subset: accumulator add, add with carry,
 * AND, arithmetic right shifts, branches, multiply/square operand checks and
 * X/Y operand prefetch. Assumes decode presents operands on issue_i and the
 * register file applies the registered write-back outputs.
 */
`timescale 1ns/10ps
module exec_unit (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  resetn_i,
	// Issue from decode
	input  wire logic                  issue_i,
	input  wire exec_pkg::op_t         op_i,
	input  wire exec_pkg::cond_t       cond_i,
	input  wire logic                  file_form_i,
	input  wire logic                  acc_b_i,
	input  wire logic [3:0]            dst_reg_i,
	input  wire logic [15:0]           opa_i,
	input  wire logic [15:0]           opb_i,
	input  wire logic signed [3:0]     acc_shift_i,
	input  wire logic [4:0]            shamt_i,
	input  wire logic [3:0]            mul_reg_m_i,
	input  wire logic [3:0]            mul_reg_n_i,
	input  wire logic [15:0]           branch_target_i,
	// Prefetch requests
	input  wire logic                  x_en_i,
	input  wire logic                  x_sel_b_i,
	input  wire logic                  x_idx_i,
	input  wire exec_pkg::pf_mod_t     x_mod_i,
	input  wire logic [3:0]            x_dst_i,
	input  wire logic [15:0]           x_ptr_i,
	input  wire logic                  y_en_i,
	input  wire logic                  y_sel_b_i,
	input  wire logic                  y_idx_i,
	input  wire exec_pkg::pf_mod_t     y_mod_i,
	input  wire logic [3:0]            y_dst_i,
	input  wire logic [15:0]           y_ptr_i,
	input  wire logic [15:0]           idx_val_i,
	// Results
	output logic                       busy_o,
	output logic                       done_o,
	output logic                       illegal_o,
	output logic                       wr_en_o,
	output logic [3:0]                 wr_reg_o,
	output logic [15:0]                wr_data_o,
	output logic                       wr_file_o,
	output logic                       acc_we_o,
	output logic                       acc_sel_o,
	output logic [39:0]                acc_o,
	output logic                       pc_load_o,
	output logic [15:0]                pc_target_o,
	output logic                       x_rd_o,
	output logic [15:0]                x_addr_o,
	output logic                       y_rd_o,
	output logic [15:0]                y_addr_o,
	// Status flags
	output logic                       c_o,
	output logic                       digit_carry_flag_o,
	output logic                       n_o,
	output logic                       overflow_flag_o,
	output logic                       z_o,
	output logic                       acc_a_overflow_flag_o,
	output logic                       acc_b_overflow_flag_o,
	output logic                       acc_a_saturated_flag_o,
	output logic                       acc_b_saturated_flag_o
);
	import exec_pkg::*;

	typedef enum {ST_IDLE, ST_BR2} st_t;
	st_t st_ff, nxt_st;

	logic [ACC_W-1:0] acc_a_ff, acc_b_ff, nxt_acc_a, nxt_acc_b;
	logic c_ff, dc_ff, n_ff, ov_ff, z_ff, oa_ff, ob_ff, sa_ff, sb_ff;
	logic nxt_c, nxt_dc, nxt_n, nxt_ov, nxt_z, nxt_oa, nxt_ob, nxt_sa, nxt_sb;
	logic busy_ff, done_ff, ill_ff, wen_ff, wfile_ff, awe_ff, asel_ff, pcl_ff;
	logic nxt_busy, nxt_done, nxt_ill, nxt_wen, nxt_wfile, nxt_awe, nxt_asel, nxt_pcl;
	logic [3:0]  default_work_reg_ff, nxt_default_work_reg;
	logic [15:0] wdat_ff, nxt_wdat, pct_ff, nxt_pct;
	logic        xrd_ff, yrd_ff, nxt_xrd, nxt_yrd;
	logic [15:0] xad_ff, yad_ff, nxt_xad, nxt_yad;
	logic        take;
	logic [16:0] sum;
	logic [4:0]  nib;
	logic [ACC_W-1:0] acc_cur, acc_add, acc_sum;
	logic        x_rd, y_rd, x_ok, y_ok;
	logic [15:0] x_addr, y_addr;
	logic [ACC_W-1:0] acco_ff, nxt_acco;

	// Selected accumulator view, registered so acc_o comes from a flip-flop
	always_comb begin
		nxt_acco = nxt_asel ? nxt_acc_b : nxt_acc_a;
	end

	// X and Y prefetch address units
	prefetch_agu #(.PTR_A(X_PTR_A), .PTR_B(X_PTR_B)) u_xagu (
		.en_i(x_en_i), .sel_b_i(x_sel_b_i), .indexed_i(x_idx_i), .mod_i(x_mod_i),
		.dst_i(x_dst_i), .ptr_val_i(x_ptr_i), .idx_val_i(idx_val_i),
		.rd_o(x_rd), .addr_o(x_addr), .ptr_we_o(), .ptr_reg_o(), .ptr_new_o(),
		.dst_ok_o(x_ok));
	prefetch_agu #(.PTR_A(Y_PTR_A), .PTR_B(Y_PTR_B)) u_yagu (
		.en_i(y_en_i), .sel_b_i(y_sel_b_i), .indexed_i(y_idx_i), .mod_i(y_mod_i),
		.dst_i(y_dst_i), .ptr_val_i(y_ptr_i), .idx_val_i(idx_val_i),
		.rd_o(y_rd), .addr_o(y_addr), .ptr_we_o(), .ptr_reg_o(), .ptr_new_o(),
		.dst_ok_o(y_ok));

	// Branch condition evaluation from the current flags
	always_comb begin
		take = 1'b0;
		case (cond_i)
			CC_C:    take = c_ff;
			CC_NC:   take = !c_ff;
			CC_N:    take = n_ff;
			CC_NN:   take = !n_ff;
			CC_OV:   take = ov_ff;
			CC_NOV:  take = !ov_ff;
			CC_Z:    take = z_ff;
			CC_NZ:   take = !z_ff;
			CC_GE:   take = (n_ff == ov_ff);
			CC_GT:   take = !z_ff && (n_ff == ov_ff);
			CC_LT:   take = (n_ff != ov_ff);
			CC_LE:   take = z_ff || (n_ff != ov_ff);
			CC_GEU:  take = c_ff;
			CC_GTU:  take = c_ff && !z_ff;
			CC_LTU:  take = !c_ff;
			CC_LEU:  take = !c_ff || z_ff;
			CC_OA:   take = oa_ff;
			CC_OB:   take = ob_ff;
			CC_SA:   take = sa_ff;
			CC_SB:   take = sb_ff;
			default: take = 1'b0;
		endcase
	end

	// Datapath: next flags, write-back and sequencing
	always_comb begin
		nxt_st = ST_IDLE;
		nxt_acc_a = acc_a_ff;  nxt_acc_b = acc_b_ff;
		nxt_c = c_ff;  nxt_dc = dc_ff;  nxt_n = n_ff;  nxt_ov = ov_ff;  nxt_z = z_ff;
		nxt_oa = oa_ff;  nxt_ob = ob_ff;  nxt_sa = sa_ff;  nxt_sb = sb_ff;
		nxt_busy = 1'b0;  nxt_done = 1'b0;  nxt_ill = 1'b0;  nxt_wen = 1'b0;
		nxt_wfile = 1'b0;  nxt_awe = 1'b0;  nxt_asel = asel_ff;  nxt_pcl = 1'b0;
		nxt_default_work_reg = file_form_i ? DEFAULT_WORK_REG : dst_reg_i;
		nxt_wdat = wdat_ff;  nxt_pct = pct_ff;
		nxt_xrd = 1'b0;  nxt_yrd = 1'b0;  nxt_xad = xad_ff;  nxt_yad = yad_ff;
		sum = 17'h00000;  nib = 5'h00;
		acc_cur = acc_b_i ? acc_b_ff : acc_a_ff;
		acc_add = 40'h0;  acc_sum = 40'h0;
		if (st_ff == ST_BR2) begin
			// Second cycle of a taken branch
			nxt_done = 1'b1;
			nxt_pcl = 1'b1;
		end else if (issue_i) begin
			nxt_done = 1'b1;
			case (op_i)
				OP_ADD_ACC: begin
					// Sign-extend then scale; positive shift moves right
					acc_add = {{(ACC_W-DATA_W){opa_i[DATA_W-1]}}, opa_i};
					if (acc_shift_i >= 0)
						acc_add = $signed(acc_add) >>> acc_shift_i;
					else
						acc_add = acc_add << (-acc_shift_i);
					acc_sum = acc_cur + acc_add;
					nxt_awe = 1'b1;
					nxt_asel = acc_b_i;
					if (acc_b_i) begin
						nxt_acc_b = acc_sum;
						nxt_ob = (acc_cur[ACC_W-1] == acc_add[ACC_W-1]) &&
							(acc_sum[ACC_W-1] != acc_cur[ACC_W-1]);
						nxt_sb = sb_ff | nxt_ob;
					end else begin
						nxt_acc_a = acc_sum;
						nxt_oa = (acc_cur[ACC_W-1] == acc_add[ACC_W-1]) &&
							(acc_sum[ACC_W-1] != acc_cur[ACC_W-1]);
						nxt_sa = sa_ff | nxt_oa;
					end
				end
				OP_ADD_WITH_CARRY_OP: begin
					sum = {1'b0, opa_i} + {1'b0, opb_i} + {16'h0000, c_ff};
					nib = {1'b0, opa_i[NIB_W-1:0]} + {1'b0, opb_i[NIB_W-1:0]} + {4'h0, c_ff};
					nxt_wdat = sum[DATA_W-1:0];
					nxt_wen = 1'b1;
					nxt_wfile = file_form_i;
					nxt_c = sum[DATA_W];
					nxt_dc = nib[NIB_W];
					nxt_n = sum[DATA_W-1];
					nxt_ov = (opa_i[DATA_W-1] == opb_i[DATA_W-1]) &&
						(sum[DATA_W-1] != opa_i[DATA_W-1]);
					nxt_z = (sum[DATA_W-1:0] == 16'h0000);
				end
				OP_AND: begin
					nxt_wdat = opa_i & opb_i;
					nxt_wen = 1'b1;
					nxt_wfile = file_form_i;
					nxt_n = nxt_wdat[DATA_W-1];
					nxt_z = (nxt_wdat == 16'h0000);
				end
				OP_ASR1: begin
					nxt_wdat = {opa_i[DATA_W-1], opa_i[DATA_W-1:1]};
					nxt_wen = 1'b1;
					nxt_wfile = file_form_i;
					nxt_c = opa_i[0];
					nxt_n = nxt_wdat[DATA_W-1];
					nxt_ov = 1'b0;
					nxt_z = (nxt_wdat == 16'h0000);
				end
				OP_ASRN: begin
					nxt_wdat = 16'($signed(opa_i) >>> shamt_i);
					nxt_wen = 1'b1;
					nxt_n = nxt_wdat[DATA_W-1];
					nxt_z = (nxt_wdat == 16'h0000);
				end
				OP_BRANCH_COND: begin
					nxt_pct = branch_target_i;
					if (take) begin
						nxt_done = 1'b0;
						nxt_busy = 1'b1;
						nxt_st = ST_BR2;
					end
				end
				OP_BRANCH_ALWAYS: begin
					nxt_pct = branch_target_i;
					nxt_done = 1'b0;
					nxt_busy = 1'b1;
					nxt_st = ST_BR2;
				end
				OP_MUL: begin
					nxt_ill = !((mul_reg_m_i >= MUL_REG_LO) && (mul_reg_n_i <= MUL_REG_HI) &&
						(mul_reg_m_i < mul_reg_n_i));
				end
				OP_SQR: begin
					nxt_ill = !((mul_reg_m_i >= MUL_REG_LO) && (mul_reg_m_i <= MUL_REG_HI));
				end
				default: nxt_done = 1'b1;
			endcase
			// Prefetch only into the multiplier operand registers
			if ((x_rd && !x_ok) || (y_rd && !y_ok))
				nxt_ill = 1'b1;
			nxt_xrd = x_rd && x_ok;
			nxt_yrd = y_rd && y_ok;
			nxt_xad = x_addr;
			nxt_yad = y_addr;
		end
	end

	// State registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff <= ST_IDLE;
			acc_a_ff <= '0;  acc_b_ff <= '0;  acco_ff <= '0;
			{c_ff, dc_ff, n_ff, ov_ff, z_ff, oa_ff, ob_ff, sa_ff, sb_ff} <= '0;
			{busy_ff, done_ff, ill_ff, wen_ff, wfile_ff, awe_ff, asel_ff, pcl_ff} <= '0;
			default_work_reg_ff <= 4'h0;  wdat_ff <= 16'h0000;  pct_ff <= 16'h0000;
			xrd_ff <= 1'b0;  yrd_ff <= 1'b0;  xad_ff <= 16'h0000;  yad_ff <= 16'h0000;
		end else begin
			st_ff <= nxt_st;
			acc_a_ff <= nxt_acc_a;  acc_b_ff <= nxt_acc_b;  acco_ff <= nxt_acco;
			{c_ff, dc_ff, n_ff, ov_ff, z_ff} <= {nxt_c, nxt_dc, nxt_n, nxt_ov, nxt_z};
			{oa_ff, ob_ff, sa_ff, sb_ff} <= {nxt_oa, nxt_ob, nxt_sa, nxt_sb};
			{busy_ff, done_ff, ill_ff, wen_ff} <= {nxt_busy, nxt_done, nxt_ill, nxt_wen};
			{wfile_ff, awe_ff, asel_ff, pcl_ff} <= {nxt_wfile, nxt_awe, nxt_asel, nxt_pcl};
			default_work_reg_ff <= nxt_default_work_reg;  wdat_ff <= nxt_wdat;  pct_ff <= nxt_pct;
			xrd_ff <= nxt_xrd;  yrd_ff <= nxt_yrd;  xad_ff <= nxt_xad;  yad_ff <= nxt_yad;
		end
	end

	// Outputs straight from flip-flops
	assign busy_o = busy_ff;
	assign done_o = done_ff;
	assign illegal_o = ill_ff;
	assign wr_en_o = wen_ff;
	assign wr_reg_o = default_work_reg_ff;
	assign wr_data_o = wdat_ff;
	assign wr_file_o = wfile_ff;
	assign acc_we_o = awe_ff;
	assign acc_sel_o = asel_ff;
	assign acc_o = acco_ff;
	assign pc_load_o = pcl_ff;
	assign pc_target_o = pct_ff;
	assign x_rd_o = xrd_ff;
	assign x_addr_o = xad_ff;
	assign y_rd_o = yrd_ff;
	assign y_addr_o = yad_ff;
	assign c_o = c_ff;
	assign digit_carry_flag_o = dc_ff;
	assign n_o = n_ff;
	assign overflow_flag_o = ov_ff;
	assign z_o = z_ff;
	assign acc_a_overflow_flag_o = oa_ff;
	assign acc_b_overflow_flag_o = ob_ff;
	assign acc_a_saturated_flag_o = sa_ff;
	assign acc_b_saturated_flag_o = sb_ff;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	acc_add_flags_a: assert property (issue_i && !busy_ff && op_i == OP_ADD_ACC |=> $stable({c_ff, n_ff, z_ff, ov_ff, dc_ff})) else $error("acc add touched alu flags");
	add_with_carry_op_sum_a: assert property (issue_i && !busy_ff && op_i == OP_ADD_WITH_CARRY_OP |=> wen_ff && wdat_ff == 16'($past(opa_i) + $past(opb_i) + 16'($past(c_ff)))) else $error("add_with_carry_op sum wrong");
	asr1_sign_a: assert property (issue_i && !busy_ff && op_i == OP_ASR1 |=> wdat_ff[15] == $past(opa_i[15]) && c_ff == $past(opa_i[0])) else $error("asr1 lost sign or carry");
	asrn_flags_a: assert property (issue_i && !busy_ff && op_i == OP_ASRN |=> $stable({c_ff, ov_ff, dc_ff})) else $error("asrn changed c or ov");
	br_taken_a: assert property (issue_i && !busy_ff && op_i == OP_BRANCH_COND && take |=> busy_ff && !done_ff ##1 done_ff && pc_load_o) else $error("taken branch not two cycles");
	br_not_taken_a: assert property (issue_i && !busy_ff && op_i == OP_BRANCH_COND && !take |=> done_ff && !pc_load_o && $stable({c_ff, n_ff, z_ff, ov_ff})) else $error("untaken branch wrong");
	sqr_range_a: assert property (issue_i && !busy_ff && op_i == OP_SQR && mul_reg_m_i < MUL_REG_LO |=> ill_ff) else $error("square reg not rejected");
	mul_pair_a: assert property (issue_i && !busy_ff && op_i == OP_MUL && mul_reg_m_i == mul_reg_n_i |=> ill_ff) else $error("mul same pair accepted");
	and_flags_a: assert property (issue_i && !busy_ff && op_i == OP_AND |=> $stable({c_ff, ov_ff})) else $error("and changed c or ov");
	file_reg_a: assert property (issue_i && !busy_ff && file_form_i |=> default_work_reg_ff == DEFAULT_WORK_REG) else $error("file form not using reg zero");
	pf_dest_a: assert property (issue_i && !busy_ff && x_en_i && x_dst_i > MUL_REG_HI |=> !xrd_ff) else $error("prefetch to bad dest");
	br_always_a: assert property (issue_i && !busy_ff && op_i == OP_BRANCH_ALWAYS |=> !done_ff ##1 done_ff && pc_load_o) else $error("unconditional branch not two cycles");

	taken_c: cover property (issue_i && op_i == OP_BRANCH_COND && take ##2 done_ff);
	add_with_carry_op_c: cover property (issue_i && op_i == OP_ADD_WITH_CARRY_OP && c_ff);
	acc_ov_c: cover property (issue_i && op_i == OP_ADD_ACC ##1 oa_ff);
	xy_pf_c: cover property (issue_i && x_rd && y_rd);

endmodule : exec_unit

// ===== verif/regfile_model.sv
/*
 * Register file model standing behind the execution unit write-back port.
 * Assumes one write pulse per completed instruction on the unit clock.
 */
`timescale 1ns/10ps
module regfile_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Write-back from the execution unit
	input  wire logic        wr_en_i,
	input  wire logic [3:0]  wr_reg_i,
	input  wire logic [15:0] wr_data_i
);
	logic [15:0] w_ff  [16];
	logic [15:0] nxt_w [16];
	// One write per pulse, other registers keep their value
	always_comb begin
		nxt_w = w_ff;
		if (wr_en_i) begin
			nxt_w[wr_reg_i] = wr_data_i;
		end
	end
	// Register the working set
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			w_ff <= '{default: 16'h0000};
		end else begin
			w_ff <= nxt_w;
		end
	end
endmodule : regfile_model

// ===== verif/dsp_core_instr_subset_bench.sv
/*
 * Self-checking bench for the execution unit with a register file model.
 * Assumes decode holds off while busy, so each instruction waits for done.
 */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module dsp_core_instr_subset_bench;
	import exec_pkg::*;
	logic clk_i, resetn_i, issue_i, file_form_i, acc_b_i, x_en_i, x_sel_b_i, x_idx_i;
	logic y_en_i, y_sel_b_i, y_idx_i, busy_o, done_o, illegal_o, wr_en_o, wr_file_o;
	logic acc_we_o, acc_sel_o, pc_load_o, x_rd_o, y_rd_o, c_o, digit_carry_flag_o, n_o, z_o;
	logic overflow_flag_o, acc_a_overflow_flag_o, acc_b_overflow_flag_o;
	logic acc_a_saturated_flag_o, acc_b_saturated_flag_o, ill_s, xr_s, yr_s, pc_s;
	logic [3:0] dst_reg_i, mul_reg_m_i, mul_reg_n_i, x_dst_i, y_dst_i, wr_reg_o;
	logic [15:0] opa_i, opb_i, branch_target_i, x_ptr_i, y_ptr_i, idx_val_i;
	logic [15:0] wr_data_o, pc_target_o, x_addr_o, y_addr_o;
	logic [39:0] acc_o;
	logic signed [3:0] acc_shift_i;
	logic [4:0] shamt_i;
	op_t op_i;
	cond_t cond_i;
	pf_mod_t x_mod_i, y_mod_i;
	int n_mismatch, samples_checked, cyc;
	wire [4:0] fl = {c_o, digit_carry_flag_o, n_o, overflow_flag_o, z_o};

	// Unit under test and far-side register file
	exec_unit uut (.clk_i, .resetn_i, .issue_i, .op_i, .cond_i, .file_form_i, .acc_b_i,
		.dst_reg_i, .opa_i, .opb_i, .acc_shift_i, .shamt_i, .mul_reg_m_i, .mul_reg_n_i,
		.branch_target_i, .x_en_i, .x_sel_b_i, .x_idx_i, .x_mod_i, .x_dst_i, .x_ptr_i,
		.y_en_i, .y_sel_b_i, .y_idx_i, .y_mod_i, .y_dst_i, .y_ptr_i, .idx_val_i, .busy_o,
		.done_o, .illegal_o, .wr_en_o, .wr_reg_o, .wr_data_o, .wr_file_o, .acc_we_o,
		.acc_sel_o, .acc_o, .pc_load_o, .pc_target_o, .x_rd_o, .x_addr_o, .y_rd_o,
		.y_addr_o, .c_o, .digit_carry_flag_o, .n_o, .overflow_flag_o, .z_o,
		.acc_a_overflow_flag_o, .acc_b_overflow_flag_o, .acc_a_saturated_flag_o,
		.acc_b_saturated_flag_o);
	regfile_model pf (.clk_i, .resetn_i, .wr_en_i(wr_en_o), .wr_reg_i(wr_reg_o),
		.wr_data_i(wr_data_o));

	// Counts, verdict and end of run
	task automatic final_report;
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : final_report

	// Issue one instruction, count cycles to completion, gather pulses
	task automatic run(input op_t op, input logic [15:0] a, input logic [15:0] b);
		op_i = op;
		opa_i = a;
		opb_i = b;
		issue_i = 1'b1;
		@(negedge clk_i);
		issue_i = 1'b0;
		cyc = 1;
		{ill_s, xr_s, yr_s, pc_s} = {illegal_o, x_rd_o, y_rd_o, pc_load_o};
		while (done_o !== 1'b1 && illegal_o !== 1'b1 && cyc < 6) begin
			@(negedge clk_i);
			cyc++;
			{ill_s, xr_s, yr_s, pc_s} |= {illegal_o, x_rd_o, y_rd_o, pc_load_o};
		end
		if (cyc == 6) begin
			n_mismatch++;
			final_report();
		end
		@(negedge clk_i);
	endtask : run

	// Single-cycle ALU operation with result and flag checks
	task automatic alu(input op_t op, input logic [15:0] a, input logic [15:0] b,
			input logic [15:0] ed, input logic [4:0] ef);
		run(op, a, b);
		`CHK("cycles", 1, cyc)
		`CHK("result", ed, wr_data_o)
		`CHK("flags", ef, fl)
	endtask : alu

	// Accumulator adds, either alignment of the word accepted
	task automatic t_acc;
		run(OP_ADD_ACC, 16'h0003, 16'h0000);
		`CHK("acc a", 1'b1, (acc_o === 40'h3 || acc_o === 40'h30000))
		acc_b_i = 1'b1;
		run(OP_ADD_ACC, 16'hfffe, 16'h0000);
		`CHK("acc b", 1'b1, (acc_o === 40'hfffffffffe || acc_o === 40'hfffffe0000))
		`CHK("acc select", 1'b1, acc_sel_o)
		acc_b_i = 1'b0;
		acc_shift_i = -4'sh1;
		run(OP_ADD_ACC, 16'h0001, 16'h0000);
		`CHK("acc a shifted", 1'b1, (acc_o === 40'h5 || acc_o === 40'h50000))
		`CHK("flags", 5'h00, fl)
	endtask : t_acc

	// Add with carry, flags as C DC N OV Z
	task automatic t_add_with_carry_op;
		alu(OP_ADD_WITH_CARRY_OP, 16'h7fff, 16'h0001, 16'h8000, 5'b01110);
		`CHK("regfile w2", 16'h8000, pf.w_ff[2])
		alu(OP_ADD_WITH_CARRY_OP, 16'hffff, 16'h0001, 16'h0000, 5'b11001);
	endtask : t_add_with_carry_op

	// AND, one-bit and multi-bit shifts, file form with carry in
	task automatic t_logic;
		alu(OP_AND, 16'h8000, 16'hff00, 16'h8000, 5'b11100);
		alu(OP_ASR1, 16'h8000, 16'h0000, 16'hc000, 5'b01100);
		alu(OP_ASR1, 16'h0001, 16'h0000, 16'h0000, 5'b11001);
		shamt_i = 5'h0f;
		alu(OP_ASRN, 16'h8000, 16'h0000, 16'hffff, 5'b11100);
		shamt_i = 5'h1f;
		alu(OP_ASRN, 16'h4000, 16'h0000, 16'h0000, 5'b11001);
		file_form_i = 1'b1;
		alu(OP_ADD_WITH_CARRY_OP, 16'h0000, 16'h0000, 16'h0001, 5'b00000);
		`CHK("file form dest", 4'h0, wr_reg_o)
		file_form_i = 1'b0;
		alu(OP_ADD_WITH_CARRY_OP, 16'hffff, 16'hffff, 16'hfffe, 5'b11100);
	endtask : t_logic

	// With C=1 N=1 OV=0 Z=0 and clear accumulator flags
	function automatic logic exp_taken(input cond_t cc);
		return cc inside {CC_C, CC_GEU, CC_GTU, CC_LE, CC_LT, CC_N, CC_NOV, CC_NZ};
	endfunction : exp_taken

	// Every condition code, then the unconditional form
	task automatic t_branch;
		for (int i = 0; i < 20; i++) begin
			cond_i = cond_t'(i);
			branch_target_i = 16'h0100 + 16'(i);
			run(OP_BRANCH_COND, 16'h0000, 16'h0000);
			`CHK("branch cycles", exp_taken(cond_t'(i)) ? 2 : 1, cyc)
			`CHK("branch taken", exp_taken(cond_t'(i)), pc_s)
			`CHK("branch flags", 5'b11100, fl)
		end
		`CHK("branch target", 16'h0113, pc_target_o)
		branch_target_i = 16'h0abc;
		run(OP_BRANCH_ALWAYS, 16'h0000, 16'h0000);
		`CHK("jump cycles", 2, cyc)
		`CHK("jump target", 16'h0abc, pc_target_o)
		`CHK("jump flags", 5'b11100, fl)
	endtask : t_branch

	// Multiply pairs and square operands over registers three to seven
	task automatic t_mul;
		for (int m = 3; m < 8; m++) begin
			for (int n = 3; n < 8; n++) begin
				mul_reg_m_i = 4'(m);
				mul_reg_n_i = 4'(n);
				run(OP_MUL, 16'h0000, 16'h0000);
				`CHK("mul refused", !(m >= 4 && m < n), ill_s)
			end
			mul_reg_n_i = 4'h0;
			run(OP_SQR, 16'h0000, 16'h0000);
			`CHK("sqr refused", m == 3, ill_s)
		end
	endtask : t_mul

	// All modifier codes, indexed form, then bad destinations
	task automatic t_prefetch;
		{mul_reg_m_i, mul_reg_n_i, x_en_i, y_en_i} = {4'h4, 4'h5, 2'b11};
		for (int k = 0; k < 8; k++) begin
			x_mod_i = pf_mod_t'(k);
			y_mod_i = pf_mod_t'(k);
			{x_dst_i, y_dst_i, x_sel_b_i, y_sel_b_i} = {4'(4 + k % 4), 4'(7 - k % 4), 2'(k)};
			run(OP_MUL, 16'h0000, 16'h0000);
			`CHK("x read", k != 0, xr_s)
			`CHK("y read", k != 0, yr_s)
			`CHK("dest refused", 1'b0, ill_s)
		end
		`CHK("x address", 16'h1000, x_addr_o)
		`CHK("y address", 16'h2000, y_addr_o)
		{x_idx_i, y_idx_i, x_sel_b_i, y_sel_b_i} = 4'hf;
		x_mod_i = PF_PLAIN;
		y_mod_i = PF_PLAIN;
		run(OP_MUL, 16'h0000, 16'h0000);
		`CHK("x indexed", 16'h1010, x_addr_o)
		`CHK("y indexed", 16'h2010, y_addr_o)
		{x_dst_i, y_dst_i} = {4'h3, 4'h8};
		run(OP_MUL, 16'h0000, 16'h0000);
		`CHK("bad dest", 3'b100, {ill_s, xr_s, yr_s})
	endtask : t_prefetch

	// Free-running clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Time-zero values, reset, then the scenarios
	initial begin
		{resetn_i, issue_i, file_form_i, acc_b_i, x_en_i, x_sel_b_i, x_idx_i} = 7'h00;
		{y_en_i, y_sel_b_i, y_idx_i, opa_i, opb_i, branch_target_i} = '0;
		op_i = OP_NOP;
		cond_i = CC_C;
		x_mod_i = PF_NONE;
		y_mod_i = PF_NONE;
		{dst_reg_i, mul_reg_m_i, mul_reg_n_i, x_dst_i, y_dst_i} = 20'h24544;
		{acc_shift_i, shamt_i} = 9'h000;
		{x_ptr_i, y_ptr_i, idx_val_i} = {16'h1000, 16'h2000, 16'h0010};
		n_mismatch = 0;
		samples_checked = 0;
		repeat (12) @(negedge clk_i);
		resetn_i = 1'b1;
		@(negedge clk_i);
		t_acc();
		t_add_with_carry_op();
		t_logic();
		t_branch();
		t_mul();
		t_prefetch();
		final_report();
	end
endmodule : dsp_core_instr_subset_bench
